// ### rtl/uart_aux_line_control.sv
`timescale 1ns/1ns

module uart_aux_line_control #(
  parameter int LAMP_HOLD = uart_aux_pkg::LAMP_HOLD_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic [uart_aux_pkg::DIV_W-1:0] i_baud_div,
  input wire logic i_rx_room,
  input wire logic i_rxd,
  input wire logic i_cts_n,
  input wire logic i_ring_wake_input_n,
  input wire logic i_enumerated,
  input wire logic i_suspend,
  input wire logic i_ref_int,
  input wire logic i_ref_ext,
  input wire logic i_cfg_load,
  input wire logic i_cfg_osc_ext,
  input wire uart_aux_pkg::pin_func_e i_cfg_func_zero,
  input wire uart_aux_pkg::pin_func_e i_cfg_func_one,
  input wire uart_aux_pkg::pin_func_e i_cfg_func_two,
  input wire uart_aux_pkg::pin_func_e i_cfg_func_three,
  input wire uart_aux_pkg::pin_func_e i_cfg_func_four,
  output logic o_tx_ready,
  output logic o_txd,
  output logic o_rts_n,
  output logic o_remote_wakeup,
  output logic o_config_io_pin_zero,
  output logic o_config_io_pin_zero_oe,
  output logic o_config_io_pin_one,
  output logic o_config_io_pin_one_oe,
  output logic o_config_io_pin_two,
  output logic o_config_io_pin_two_oe,
  output logic o_config_io_pin_three,
  output logic o_config_io_pin_three_oe,
  output logic o_config_io_pin_four,
  output logic o_config_io_pin_four_oe
);

  localparam int DW = uart_aux_pkg::DIV_W;
  localparam int NP = uart_aux_pkg::NUM_PINS;

  typedef struct packed {
    uart_aux_pkg::tx_state_e st;
    logic [DW-1:0] div;
    logic [DW-1:0] cnt;
    logic [2:0] bit_idx;
    logic [7:0] shreg;
    logic drv_en;
    logic txd;
    logic tx_rdy;
    logic send_evt;
    logic rts_n;
    logic pwr_n;
    logic awake;
    logic wake_req;
    logic wake_done;
    logic clk_out;
    logic osc_ext;
    uart_aux_pkg::pin_func_e [NP-1:0] func;
    logic [NP-1:0] pin_o;
    logic [NP-1:0] pin_oe;
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic cts_s1;
    logic cts_s2;
    logic ri_s1;
    logic ri_s2;
    logic refi_s1;
    logic refi_s2;
    logic refe_s1;
    logic refe_s2;
  } ctl_s;

  ctl_s q;
  ctl_s d;
  ctl_s rst_val;

  logic send_act;
  logic recv_act;
  logic recv_evt;
  logic [DW-1:0] div_sel;
  uart_aux_pkg::pin_func_e [NP-1:0] func_in;

  assign func_in = '{i_cfg_func_four, i_cfg_func_three, i_cfg_func_two,
                     i_cfg_func_one, i_cfg_func_zero};

  // Start-bit edge seen on the resynchronised receive line
  assign recv_evt = q.rx_s3 && !q.rx_s2;

  // ==========================================================
  // Activity one-shots
  lamp_one_shot #(
    .HOLD(LAMP_HOLD)
  ) u_send_shot (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_trig(q.send_evt),
    .o_active(send_act)
  );

  lamp_one_shot #(
    .HOLD(LAMP_HOLD)
  ) u_recv_shot (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_trig(recv_evt),
    .o_active(recv_act)
  );

  // ==========================================================
  // Reset value
  always_comb begin
    rst_val = '0;
    rst_val.st = uart_aux_pkg::TX_IDLE;
    rst_val.div = uart_aux_pkg::MIN_DIV;
    rst_val.txd = 1'b1;
    rst_val.rts_n = 1'b1;
    rst_val.pwr_n = 1'b1;
    rst_val.awake = 1'b1;
    rst_val.osc_ext = uart_aux_pkg::OSC_EXT_RST;
    rst_val.func = '{uart_aux_pkg::PIN4_RST, uart_aux_pkg::PIN3_RST,
                     uart_aux_pkg::PIN2_RST, uart_aux_pkg::PIN1_RST,
                     uart_aux_pkg::PIN0_RST};
    rst_val.rx_s1 = 1'b1;
    rst_val.rx_s2 = 1'b1;
    rst_val.rx_s3 = 1'b1;
    rst_val.cts_s1 = 1'b1;
    rst_val.cts_s2 = 1'b1;
    rst_val.ri_s1 = 1'b1;
    rst_val.ri_s2 = 1'b1;
  end

  // Slower divisors pass through; faster ones are clamped to the top rate
  assign div_sel = (i_baud_div < uart_aux_pkg::MIN_DIV) ?
                   uart_aux_pkg::MIN_DIV : i_baud_div;

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.send_evt = 1'b0;
    d.rx_s1 = i_rxd;
    d.rx_s2 = q.rx_s1;
    d.rx_s3 = q.rx_s2;
    d.cts_s1 = i_cts_n;
    d.cts_s2 = q.cts_s1;
    d.ri_s1 = i_ring_wake_input_n;
    d.ri_s2 = q.ri_s1;
    d.refi_s1 = i_ref_int;
    d.refi_s2 = q.refi_s1;
    d.refe_s1 = i_ref_ext;
    d.refe_s2 = q.refe_s1;

    if (i_cfg_load) begin
      d.func = func_in;
      d.osc_ext = i_cfg_osc_ext;
    end

    // Transmit sequencer; the enable is only ever set on leaving idle
    case (q.st)
      uart_aux_pkg::TX_IDLE: begin
        // Recheck the synchronised line so a fresh clear-to-send stop still holds
        if (i_tx_valid && q.tx_rdy && !q.cts_s2) begin
          d.st = uart_aux_pkg::TX_LEAD;
          d.div = div_sel;
          d.cnt = div_sel - DW'(1);
          d.shreg = i_tx_data;
          d.drv_en = 1'b1;
        end
      end
      uart_aux_pkg::TX_LEAD: begin
        if (q.cnt == '0) begin
          d.st = uart_aux_pkg::TX_START;
          d.cnt = q.div - DW'(1);
          d.txd = 1'b0;
          d.send_evt = 1'b1;
        end else begin
          d.cnt = q.cnt - DW'(1);
        end
      end
      uart_aux_pkg::TX_START: begin
        if (q.cnt == '0) begin
          d.st = uart_aux_pkg::TX_DATA;
          d.cnt = q.div - DW'(1);
          d.bit_idx = '0;
          d.txd = q.shreg[0];
          d.shreg = {1'b0, q.shreg[7:1]};
        end else begin
          d.cnt = q.cnt - DW'(1);
        end
      end
      uart_aux_pkg::TX_DATA: begin
        if (q.cnt == '0) begin
          d.cnt = q.div - DW'(1);
          if (q.bit_idx == uart_aux_pkg::LAST_BIT) begin
            d.st = uart_aux_pkg::TX_STOP;
            d.txd = 1'b1;
            d.drv_en = 1'b0;
          end else begin
            d.bit_idx = q.bit_idx + 3'd1;
            d.txd = q.shreg[0];
            d.shreg = {1'b0, q.shreg[7:1]};
          end
        end else begin
          d.cnt = q.cnt - DW'(1);
        end
      end
      uart_aux_pkg::TX_STOP: begin
        if (q.cnt == '0) begin
          d.st = uart_aux_pkg::TX_IDLE;
        end else begin
          d.cnt = q.cnt - DW'(1);
        end
      end
      default: begin
        d.st = uart_aux_pkg::TX_IDLE;
        d.drv_en = 1'b0;
        d.txd = 1'b1;
      end
    endcase

    // New characters wait while the partner holds clear-to-send high
    d.tx_rdy = (d.st == uart_aux_pkg::TX_IDLE) && !q.cts_s2;
    d.rts_n = !i_rx_room;

    d.pwr_n = !(i_enumerated && !i_suspend);
    d.awake = !i_suspend;

    // One wakeup request per suspend, so a held ring line does not repeat it
    if (!i_suspend) begin
      d.wake_req = 1'b0;
      d.wake_done = 1'b0;
    end else begin
      d.wake_req = !q.ri_s2 && !q.wake_done;
      d.wake_done = q.wake_done || d.wake_req;
    end

    d.clk_out = (q.osc_ext ? q.refe_s2 : q.refi_s2) && !i_suspend;

    for (int i = 0; i < NP; i++) begin
      case (q.func[i])
        uart_aux_pkg::FN_SEND_LAMP: begin
          d.pin_o[i] = 1'b0;
          d.pin_oe[i] = send_act;
        end
        uart_aux_pkg::FN_RECV_LAMP: begin
          d.pin_o[i] = 1'b0;
          d.pin_oe[i] = recv_act;
        end
        uart_aux_pkg::FN_ANY_LAMP: begin
          d.pin_o[i] = 1'b0;
          d.pin_oe[i] = send_act || recv_act;
        end
        uart_aux_pkg::FN_LINE_DRV: begin
          // Next-state copy keeps the pin edges in step with o_txd
          d.pin_o[i] = d.drv_en;
          d.pin_oe[i] = 1'b1;
        end
        uart_aux_pkg::FN_POWER_EN: begin
          d.pin_o[i] = q.pwr_n;
          d.pin_oe[i] = 1'b1;
        end
        uart_aux_pkg::FN_SLEEP_IND: begin
          d.pin_o[i] = q.awake;
          d.pin_oe[i] = 1'b1;
        end
        uart_aux_pkg::FN_CLK_OUT: begin
          d.pin_o[i] = q.clk_out;
          d.pin_oe[i] = 1'b1;
        end
        default: begin
          d.pin_o[i] = 1'b0;
          d.pin_oe[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      q <= rst_val;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign o_tx_ready = q.tx_rdy;
  assign o_txd = q.txd;
  assign o_rts_n = q.rts_n;
  assign o_remote_wakeup = q.wake_req;
  assign o_config_io_pin_zero = q.pin_o[0];
  assign o_config_io_pin_zero_oe = q.pin_oe[0];
  assign o_config_io_pin_one = q.pin_o[1];
  assign o_config_io_pin_one_oe = q.pin_oe[1];
  assign o_config_io_pin_two = q.pin_o[2];
  assign o_config_io_pin_two_oe = q.pin_oe[2];
  assign o_config_io_pin_three = q.pin_o[3];
  assign o_config_io_pin_three_oe = q.pin_oe[3];
  assign o_config_io_pin_four = q.pin_o[4];
  assign o_config_io_pin_four_oe = q.pin_oe[4];

  // ==========================================================
  // Checks
  lead_then_start_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    (q.st == uart_aux_pkg::TX_LEAD && q.cnt == '0)
    |=> q.st == uart_aux_pkg::TX_START && !q.txd && q.drv_en)
    else $error("start bit did not follow the enable lead");

  lead_idle_line_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    q.st == uart_aux_pkg::TX_LEAD |-> q.drv_en && q.txd && q.cnt < q.div)
    else $error("lead period shows wrong line state");

  stop_release_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    q.st == uart_aux_pkg::TX_STOP |-> !q.drv_en && q.txd)
    else $error("driver enable held into stop bit");

  enable_only_tx_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    q.drv_en |-> q.st inside {uart_aux_pkg::TX_LEAD, uart_aux_pkg::TX_START,
                              uart_aux_pkg::TX_DATA})
    else $error("driver enable high outside a character");

  rate_ceiling_a: assert property (
    @(posedge i_clk) disable iff (i_srst) q.div >= uart_aux_pkg::MIN_DIV)
    else $error("bit period below top-rate limit");

  cts_blocks_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    (q.cts_s2 && q.st == uart_aux_pkg::TX_IDLE) |=> q.st == uart_aux_pkg::TX_IDLE)
    else $error("character started while clear-to-send was high");

  power_suspend_a: assert property (
    @(posedge i_clk) disable iff (i_srst) i_suspend |=> q.pwr_n && !q.awake)
    else $error("power enable or suspend indicator wrong in suspend");

  power_enum_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    (i_enumerated && !i_suspend) |=> !q.pwr_n && q.awake)
    else $error("power enable not low after enumeration");

  ring_wakeup_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    (i_suspend && !q.ri_s2 && !q.wake_done) |=> q.wake_req ##1 !q.wake_req)
    else $error("ring input did not give one wakeup pulse");

  clock_stops_a: assert property (
    @(posedge i_clk) disable iff (i_srst) i_suspend |=> !q.clk_out)
    else $error("clock output ran in suspend");

endmodule

// ### rtl/uart_aux_pkg.sv
package uart_aux_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int MAX_BAUD = 3_000_000;
  localparam int DIV_W = 16;
  // Smallest divisor that keeps the line at or below the top rate, rounded up
  localparam logic [DIV_W-1:0] MIN_DIV = DIV_W'((CLK_HZ + MAX_BAUD - 1) / MAX_BAUD);
  localparam int LAMP_HOLD_MS = 50;
  localparam int LAMP_HOLD_CYC = (CLK_HZ / 1000) * LAMP_HOLD_MS;

  // ==========================================================
  // Character format
  localparam int DATA_BITS = 8;
  localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);
  localparam int NUM_PINS = 5;

  // ==========================================================
  // Functions a configurable pin can carry
  typedef enum logic [2:0] {
    FN_SEND_LAMP,
    FN_RECV_LAMP,
    FN_ANY_LAMP,
    FN_LINE_DRV,
    FN_POWER_EN,
    FN_SLEEP_IND,
    FN_CLK_OUT
  } pin_func_e;

  // ==========================================================
  // Factory configuration
  localparam pin_func_e PIN0_RST = FN_SEND_LAMP;
  localparam pin_func_e PIN1_RST = FN_RECV_LAMP;
  localparam pin_func_e PIN2_RST = FN_LINE_DRV;
  localparam pin_func_e PIN3_RST = FN_POWER_EN;
  localparam pin_func_e PIN4_RST = FN_SLEEP_IND;
  localparam logic OSC_EXT_RST = 1'b0;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_LEAD,
    TX_START,
    TX_DATA,
    TX_STOP
  } tx_state_e;

endpackage

// ### rtl/lamp_one_shot.sv
`timescale 1ns/1ns

module lamp_one_shot #(
  parameter int HOLD = 16
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_trig,
  output logic o_active
);

  localparam int CW = $clog2(HOLD + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic active;
  } shot_s;

  shot_s q;
  shot_s d;

  // ==========================================================
  // Retriggerable stretch
  always_comb begin
    d = q;
    if (i_trig) begin
      d.cnt = CW'(HOLD);
      d.active = 1'b1;
    end else if (q.cnt > CW'(1)) begin
      d.cnt = q.cnt - CW'(1);
    end else begin
      d.cnt = '0;
      d.active = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_active = q.active;

  trig_lights_a: assert property (
    @(posedge i_clk) disable iff (i_srst) i_trig |=> o_active && q.cnt == CW'(HOLD))
    else $error("lamp one-shot did not start on a transfer event");

  hold_expires_a: assert property (
    @(posedge i_clk) disable iff (i_srst) (q.cnt == CW'(1) && !i_trig) |=> !o_active)
    else $error("lamp one-shot did not end after its hold time");

endmodule

// ### sim/uart_far_end.sv
`timescale 1ns/1ns

// ==========================================
// Far-side serial partner
module uart_far_end (
  input wire logic i_clk,
  input wire logic i_txd,
  input wire logic i_drv_en,
  input wire logic [15:0] i_div,
  input wire logic i_block,
  input wire logic i_poke,
  input wire logic i_ring,
  output logic o_rxd,
  output logic o_cts_n,
  output logic o_ring_n,
  output logic [7:0] o_byte
);
  int d;
  assign o_cts_n = i_block;
  assign o_ring_n = !i_ring;
  // Own echo is masked by the driver enable, so only poke traffic reaches the device's receive input
  assign o_rxd = i_drv_en | (i_txd & !i_poke);
  always begin
    @(negedge i_txd);
    d = (i_div < uart_aux_pkg::MIN_DIV) ? int'(uart_aux_pkg::MIN_DIV) : int'(i_div);
    repeat (d + d / 2) @(posedge i_clk);
    for (int k = 0; k < 8; k++) begin
      o_byte[k] = i_txd;
      repeat (d) @(posedge i_clk);
    end
  end
endmodule

// ### sim/uart_aux_line_control_tb.sv
`timescale 1ns/1ns

module uart_aux_line_control_tb;
  localparam int HOLD = 8;
  logic clk = 1'h0, srst = 1'h1, tx_valid = 1'h0, rx_room = 1'h1, enum_done = 1'h0;
  logic susp = 1'h0, ref_int = 1'h0, ref_ext = 1'h0, cfg_load = 1'h0, osc_ext = 1'h0;
  logic block = 1'h0, poke = 1'h0, ring = 1'h0, ext_run = 1'h0;
  logic [7:0] tx_data = 8'h00;
  logic [15:0] baud_div = 16'h0007;
  uart_aux_pkg::pin_func_e cfg [5];
  wire ready, txd, rts_n, wake, rxd, cts_n, ring_n;
  wire [4:0] pv, po;
  wire [7:0] pbyte;
  wire [13:0] obs = {wake, rts_n, ready, txd, pv, po};
  // Echo gate follows pin two only while it carries the line driver
  wire drv_pin = pv[2] && cfg[2] == uart_aux_pkg::FN_LINE_DRV;
  int error_cnt = 0, checked = 0, cyc = 0, c, n1;
  int lit [5];

  uart_aux_line_control #(.LAMP_HOLD(HOLD)) uut (
    .i_clk(clk), .i_srst(srst), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .i_baud_div(baud_div), .i_rx_room(rx_room), .i_rxd(rxd), .i_cts_n(cts_n),
    .i_ring_wake_input_n(ring_n), .i_enumerated(enum_done), .i_suspend(susp),
    .i_ref_int(ref_int), .i_ref_ext(ref_ext), .i_cfg_load(cfg_load),
    .i_cfg_osc_ext(osc_ext), .i_cfg_func_zero(cfg[0]), .i_cfg_func_one(cfg[1]),
    .i_cfg_func_two(cfg[2]), .i_cfg_func_three(cfg[3]), .i_cfg_func_four(cfg[4]),
    .o_tx_ready(ready), .o_txd(txd), .o_rts_n(rts_n), .o_remote_wakeup(wake),
    .o_config_io_pin_zero(pv[0]), .o_config_io_pin_zero_oe(po[0]),
    .o_config_io_pin_one(pv[1]), .o_config_io_pin_one_oe(po[1]),
    .o_config_io_pin_two(pv[2]), .o_config_io_pin_two_oe(po[2]),
    .o_config_io_pin_three(pv[3]), .o_config_io_pin_three_oe(po[3]),
    .o_config_io_pin_four(pv[4]), .o_config_io_pin_four_oe(po[4])
  );

  uart_far_end far (
    .i_clk(clk), .i_txd(txd), .i_drv_en(drv_pin), .i_div(baud_div), .i_block(block),
    .i_poke(poke), .i_ring(ring), .o_rxd(rxd), .o_cts_n(cts_n), .o_ring_n(ring_n),
    .o_byte(pbyte)
  );

  // ==========================================
  // Clock, reference sources, watchdog
  always #25 clk = !clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ref_int <= (cyc % 6) < 3;
    ref_ext <= ext_run && (cyc % 10) < 5;
    if (cyc == 20000) begin
      fail("timeout");
      stop_test();
    end
  end
  // Lit time of every pin, so stretch lengths can be measured afterwards
  always @(negedge clk) begin
    foreach (lit[i]) if (po[i] === 1'h1) lit[i]++;
  end

  // ==========================================
  // Helpers
  task automatic fail(input string m);
    error_cnt++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'h1) fail(m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic waitfor(input int s, input logic e, input int lim, input string m);
    int n;
    n = 0;
    while (obs[s] !== e && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(obs[s] === e, m);
  endtask
  task automatic toggles(input int s, input int n, output int cnt);
    logic l;
    cnt = 0;
    l = obs[s];
    repeat (n) begin
      @(negedge clk);
      if (obs[s] !== l) cnt++;
      l = obs[s];
    end
  endtask
  task automatic load(input logic ext);
    @(posedge clk);
    osc_ext <= ext;
    cfg_load <= 1'h1;
    @(posedge clk);
    cfg_load <= 1'h0;
    tick(3);
  endtask
  task automatic blink(input int gap);
    foreach (lit[i]) lit[i] = 0;
    repeat (gap > 0 ? 2 : 1) begin
      @(posedge clk);
      poke <= 1'h1;
      repeat (2) @(posedge clk);
      poke <= 1'h0;
      repeat (gap) @(posedge clk);
    end
    tick(30);
  endtask
  task automatic send(input logic [7:0] b, input logic [15:0] div);
    int d, rise, start, fall;
    logic lamp, echo;
    d = (div < uart_aux_pkg::MIN_DIV) ? int'(uart_aux_pkg::MIN_DIV) : int'(div);
    rise = -1;
    start = -1;
    fall = -1;
    lamp = 1'h0;
    echo = 1'h0;
    @(posedge clk);
    tx_valid <= 1'h1;
    tx_data <= b;
    baud_div <= div;
    @(negedge clk);
    while (ready !== 1'h1) @(negedge clk);
    @(posedge clk);
    tx_valid <= 1'h0;
    for (int k = 0; k < 20 * d && fall < 0; k++) begin
      @(negedge clk);
      if (rise < 0 && pv[2] === 1'h1) rise = k;
      if (start < 0 && txd === 1'h0) start = k;
      if (rise >= 0 && pv[2] === 1'h0) fall = k;
      if (po[0] === 1'h1 && pv[0] === 1'h0) lamp = 1'h1;
      if (po[1] === 1'h1) echo = 1'h1;
    end
    chk(start - rise == d, "driver lead");
    chk(fall - start == 9 * d, "driver drop");
    tick(2 * d);
    chk(pv[2] === 1'h0 && pbyte === b, "char");
    chk(lamp && !echo, "lamps in send");
  endtask
  task automatic done(input string t);
    $display("test %s finished", t);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================
  // Tests
  initial begin
    cfg = '{uart_aux_pkg::PIN0_RST, uart_aux_pkg::PIN1_RST, uart_aux_pkg::PIN2_RST,
      uart_aux_pkg::PIN3_RST, uart_aux_pkg::PIN4_RST};
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    tick(3);
    chk(po === 5'h1c && pv === 5'h18, "factory pins");
    done("factory");
    send(8'h00, 16'h0003);
    send(8'ha5, 16'h000a);
    done("transmit");
    @(posedge clk);
    block <= 1'h1;
    rx_room <= 1'h0;
    tick(4);
    chk(ready === 1'h0 && rts_n === 1'h1, "flow stop");
    @(posedge clk);
    block <= 1'h0;
    rx_room <= 1'h1;
    tick(4);
    chk(ready === 1'h1 && rts_n === 1'h0, "flow go");
    done("handshake");
    blink(0);
    n1 = lit[1];
    chk(n1 >= HOLD && n1 <= HOLD + 2 && pv[1] === 1'h0, "stretch");
    blink(4);
    chk(lit[1] > n1 && lit[0] == 0, "retrigger");
    done("receive lamp");
    @(posedge clk);
    cfg <= '{uart_aux_pkg::FN_ANY_LAMP, uart_aux_pkg::FN_CLK_OUT,
      uart_aux_pkg::FN_SLEEP_IND, uart_aux_pkg::FN_RECV_LAMP,
      uart_aux_pkg::FN_SEND_LAMP};
    load(1'h0);
    blink(0);
    chk(lit[0] > 0 && lit[3] > 0 && lit[4] == 0, "lamp funcs");
    chk(po[2] === 1'h1 && pv[2] === 1'h1, "moved indicator");
    toggles(6, 40, c);
    chk(c > 0, "clock out");
    load(1'h1);
    toggles(6, 40, c);
    chk(c == 0, "ext idle");
    ext_run <= 1'h1;
    toggles(6, 60, c);
    chk(c > 0, "ext runs");
    done("config");
    @(posedge clk);
    cfg <= '{uart_aux_pkg::FN_SEND_LAMP, uart_aux_pkg::FN_CLK_OUT,
      uart_aux_pkg::FN_LINE_DRV, uart_aux_pkg::FN_POWER_EN,
      uart_aux_pkg::FN_SLEEP_IND};
    load(1'h0);
    @(posedge clk);
    enum_done <= 1'h1;
    waitfor(8, 1'h0, 4, "power on");
    @(posedge clk);
    susp <= 1'h1;
    waitfor(8, 1'h1, 4, "power off");
    waitfor(9, 1'h0, 4, "sleep low");
    toggles(6, 30, c);
    chk(c == 0 && pv[1] === 1'h0 && pv[4] === 1'h0, "suspend holds");
    @(posedge clk);
    ring <= 1'h1;
    waitfor(13, 1'h1, 8, "wakeup");
    toggles(13, 20, c);
    chk(c == 1, "one wakeup");
    @(posedge clk);
    ring <= 1'h0;
    susp <= 1'h0;
    waitfor(9, 1'h1, 4, "awake");
    chk(pv[3] === 1'h0, "power back");
    @(posedge clk);
    ring <= 1'h1;
    toggles(13, 10, c);
    chk(c == 0, "no wake awake");
    done("suspend");
    stop_test();
  end
endmodule
